// File: rrp_rx_port.sv
/*
  One port of the reduced receive interface: takes decoded nibbles from the
  receive decoder, buffers them, and serialises them as dibits with the
  combined carrier/data-valid signal and receive error. Transmit pair is
  registered through toward the transmit path.
  Assumes CLK is the shared reference clock, all inputs synchronous to it,
  and the decoder pushes nibbles only once it has locked.
*/
`timescale 1ns/100ps
module rrp_rx_port (
  input  wire logic                         CLK,
  input  wire logic                         SYS_RST,
  input  wire logic                         CE,
  input  wire logic                         SPEED_10M,
  input  wire logic                         CARRIER,
  input  wire logic                         DECODE_LOCK,
  input  wire logic                         FALSE_CARRIER,
  input  wire logic                         NIB_VALID,
  input  wire logic [rrp_pkg::NIB_W-1:0]    NIB_DATA,
  input  wire logic                         NIB_ERR,
  output var  logic                         NIB_READY,
  input  wire logic [rrp_pkg::DIBIT_W-1:0]  TXD,
  input  wire logic                         TX_EN,
  output var  logic [rrp_pkg::DIBIT_W-1:0]  TX_DIBIT,
  output var  logic                         TX_ACTIVE,
  output var  logic [rrp_pkg::DIBIT_W-1:0]  RXD,
  output var  logic                         CRS_DV,
  output var  logic                         RX_ER
);
  import rrp_pkg::*;

  // ==========================================================================
  // state
  typedef struct packed {
    rrp_state_type      state;
    logic               phase;
    logic [DIV_W-1:0]   div;
    logic [NIB_W-1:0]   nib;
    logic               nib_err;
    logic [DIBIT_W-1:0] rxd;
    logic               crs_dv;
    logic               rx_er;
    logic [DIBIT_W-1:0] txd;
    logic               tx_en;
  } rrp_port_state_type;

  localparam rrp_port_state_type PORT_RST = '{
    state:   RRP_IDLE,
    phase:   PHASE_SECOND,
    div:     DIV_RST,
    nib:     NIB_RST,
    nib_err: 1'b0,
    rxd:     DIBIT_IDLE,
    crs_dv:  1'b0,
    rx_er:   1'b0,
    txd:     DIBIT_IDLE,
    tx_en:   1'b0
  };

  rrp_port_state_type q;
  rrp_port_state_type d;
  logic               tick;
  logic               boundary;
  logic               mid;
  logic               pop;

  rrp_fifo_if #(.WIDTH(FIFO_W)) fifo_c ();

  rrp_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk  (CLK),
    .rst  (SYS_RST),
    .ce   (CE),
    .port (fifo_c.buffer)
  );

  // ==========================================================================
  // buffer hookup
  // nibbles are only taken while a locked frame is running
  assign fifo_c.in_valid  = NIB_VALID && (q.state == RRP_DATA);
  assign fifo_c.in_data   = {NIB_ERR, NIB_DATA};
  assign fifo_c.out_ready = pop;
  assign fifo_c.flush     = (q.state == RRP_IDLE);

  // ==========================================================================
  // next state
  always_comb begin
    d   = q;
    pop = 1'b0;

    d.txd   = TXD;
    d.tx_en = TX_EN;

    tick = !SPEED_10M || (q.div == DIV_LAST);
    if (SPEED_10M && !tick) begin
      d.div = DIV_W'(q.div + 1'b1);
    end else begin
      d.div = DIV_RST;
    end
    if (tick) begin
      d.phase = ~q.phase;
    end
    // boundary: next dibit shown is the first of a nibble
    boundary = tick && (q.phase == PHASE_SECOND);
    mid      = tick && (q.phase == PHASE_FIRST);

    unique case (q.state)
      RRP_IDLE: begin
        d.rxd   = DIBIT_IDLE;
        d.rx_er = 1'b0;
        if (CARRIER) begin
          d.state  = RRP_WAIT_LOCK;
          d.crs_dv = 1'b1;
          d.phase  = PHASE_SECOND;
          d.div    = DIV_RST;
        end
      end

      RRP_WAIT_LOCK: begin
        d.rxd = DIBIT_IDLE;
        if (FALSE_CARRIER && !SPEED_10M) begin
          d.state = RRP_FALSE;
          d.rxd   = DIBIT_FALSE;
          d.rx_er = 1'b1;
        end else if (DECODE_LOCK) begin
          d.state = RRP_DATA;
          d.phase = PHASE_SECOND;
          d.div   = DIV_LAST;
          d.nib   = NIB_RST;
        end else if (boundary && !CARRIER) begin
          d.state  = RRP_IDLE;
          d.crs_dv = 1'b0;
        end
      end

      RRP_DATA, RRP_DRAIN: begin
        if (boundary) begin
          if (!CARRIER || q.state == RRP_DRAIN) begin
            d.crs_dv = 1'b0;
          end else begin
            d.crs_dv = 1'b1;
          end
          if (fifo_c.out_valid) begin
            pop       = 1'b1;
            d.nib     = fifo_c.out_data[NIB_W-1:0];
            d.nib_err = fifo_c.out_data[ERR_BIT];
            if (!CARRIER) begin
              d.state = RRP_DRAIN;
            end
          end else begin
            // underflow shows idle dibits rather than repeating data
            d.nib     = NIB_RST;
            d.nib_err = 1'b0;
            if (!CARRIER || q.state == RRP_DRAIN) begin
              d.state = RRP_IDLE;
            end
          end
          d.rxd   = rrp_dibit(d.nib, PHASE_FIRST);
          d.rx_er = d.nib_err && (d.state != RRP_IDLE);
          if (d.state == RRP_IDLE) begin
            d.rxd = DIBIT_IDLE;
          end
        end else if (mid) begin
          d.rxd = rrp_dibit(q.nib, PHASE_SECOND);
          if (q.state == RRP_DRAIN) begin
            d.crs_dv = 1'b1;
          end
        end
      end

      RRP_FALSE: begin
        d.crs_dv = 1'b1;
        d.rxd    = DIBIT_FALSE;
        d.rx_er  = 1'b1;
        if (boundary && !CARRIER) begin
          d.state  = RRP_IDLE;
          d.crs_dv = 1'b0;
          d.rxd    = DIBIT_IDLE;
          d.rx_er  = 1'b0;
        end
      end
    endcase
  end

  // ==========================================================================
  // registers
  // all receive outputs change on the clock
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      q <= PORT_RST;
    end else if (CE) begin
      q <= d;
    end
  end

  assign RXD       = q.rxd;
  assign CRS_DV    = q.crs_dv;
  assign RX_ER     = q.rx_er;
  assign TX_DIBIT  = q.txd;
  assign TX_ACTIVE = q.tx_en;
  assign NIB_READY = fifo_c.in_ready;

endmodule : rrp_rx_port

// File: rrp_pkg.sv
/*
  Shared constants, state enumeration and timing counts for one port's reduced
  receive interface: dibit serialiser, carrier/data-valid generation, nibble buffer.
  Assumes a single reference clock that also clocks the upstream decoder.
*/
package rrp_pkg;

  // ==========================================================================
  // widths and buffer shape
  localparam int NIB_W      = 4;
  localparam int ERR_BIT    = 4;
  localparam int FIFO_W     = 5;
  localparam int FIFO_DEPTH = 16;
  localparam int DIBIT_W    = 2;

  // ==========================================================================
  // timing: reference clock against the 10 Mbps dibit rate
  localparam int REFCLK_HZ     = 50_000_000;
  localparam int DIBIT_HZ_10M  = 5_000_000;
  localparam int HOLD_10M      = REFCLK_HZ / DIBIT_HZ_10M;
  localparam int DIV_W         = 4;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(HOLD_10M - 1);
  localparam logic [DIV_W-1:0] DIV_RST  = 4'h0;

  // ==========================================================================
  // dibit patterns and reset values
  localparam logic [DIBIT_W-1:0] DIBIT_IDLE  = 2'h0;
  localparam logic [DIBIT_W-1:0] DIBIT_FALSE = 2'h2;
  localparam logic [NIB_W-1:0]   NIB_RST     = 4'h0;
  localparam logic               PHASE_FIRST = 1'b0;
  localparam logic               PHASE_SECOND = 1'b1;

  // ==========================================================================
  // receive sequence
  typedef enum logic [2:0] {
    RRP_IDLE,
    RRP_WAIT_LOCK,
    RRP_DATA,
    RRP_DRAIN,
    RRP_FALSE
  } rrp_state_type;

  // dibit of a nibble for the given half
  function automatic logic [DIBIT_W-1:0] rrp_dibit(input logic [NIB_W-1:0] nib,
                                                   input logic             half);
    rrp_dibit = half ? nib[3:2] : nib[1:0];
  endfunction : rrp_dibit

endpackage : rrp_pkg

// File: rrp_fifo_if.sv
/*
  Valid/ready carrier between the receive port and its nibble buffer.
  Assumes both ends share the reference clock.
*/
`timescale 1ns/100ps
interface rrp_fifo_if #(parameter int WIDTH = 5);
  logic             in_valid;
  logic             in_ready;
  logic [WIDTH-1:0] in_data;
  logic             out_valid;
  logic             out_ready;
  logic [WIDTH-1:0] out_data;
  logic             flush;

  modport buffer (input in_valid, in_data, out_ready, flush,
                  output in_ready, out_valid, out_data);
  modport user   (output in_valid, in_data, out_ready, flush,
                  input in_ready, out_valid, out_data);
endinterface : rrp_fifo_if

// File: rrp_fifo.sv
/*
  Parameterised synchronous FIFO with registered full/empty flags.
  Assumes clock enable and reset shared with the user of the buffer.
*/
`timescale 1ns/100ps
module rrp_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 16
) (
  input  wire logic   clk,
  input  wire logic   rst,
  input  wire logic   ce,
  rrp_fifo_if.buffer  port
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
    logic                        not_empty;
    logic                        not_full;
  } rrp_fifo_state_type;

  rrp_fifo_state_type q;
  rrp_fifo_state_type d;
  logic               push;
  logic               pop;

  // ==========================================================================
  // next state
  always_comb begin
    d    = q;
    push = port.in_valid && q.not_full;
    pop  = port.out_ready && q.not_empty;
    if (push) begin
      d.mem[q.wr] = port.in_data;
      d.wr        = AW'(q.wr + 1'b1);
    end
    if (pop) begin
      d.rd = AW'(q.rd + 1'b1);
    end
    d.cnt = (AW+1)'(q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    // stale nibbles from a finished frame must not leak into the next
    if (port.flush) begin
      d.wr  = '0;
      d.rd  = '0;
      d.cnt = '0;
    end
    // flags registered so the filling side sees ready straight from a flop
    d.not_empty = (d.cnt != '0);
    d.not_full  = (d.cnt != (AW+1)'(DEPTH));
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q          <= '0;
      q.not_full <= 1'b1;
    end else if (ce) begin
      q <= d;
    end
  end

  assign port.in_ready  = q.not_full;
  assign port.out_valid = q.not_empty;
  assign port.out_data  = q.mem[q.rd];

endmodule : rrp_fifo

// File: rrp_rx_port_sva.sv
/*
  pin checks for one receive port
  assumes CE tied high
*/
`timescale 1ns/100ps
module rrp_rx_port_sva
  import rrp_pkg::*;
(
  input wire logic                        CLK,
  input wire logic                        SYS_RST,
  input wire logic                        SPEED_10M,
  input wire logic                        CARRIER,
  input wire logic                        FALSE_CARRIER,
  input wire logic [rrp_pkg::DIBIT_W-1:0] TXD,
  input wire logic                        TX_EN,
  input wire logic [rrp_pkg::DIBIT_W-1:0] TX_DIBIT,
  input wire logic                        TX_ACTIVE,
  input wire logic [rrp_pkg::DIBIT_W-1:0] RXD,
  input wire logic                        CRS_DV,
  input wire logic                        RX_ER
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // ====
  // checks
  carrier_rise_a:
    assert property (!SPEED_10M && CARRIER && !CRS_DV && !$past(CRS_DV) |=> CRS_DV)
      else $error("carrier not flagged");
  rise_zero_a:
    assert property (!SPEED_10M && $rose(CRS_DV) && !$past(CRS_DV, 2) |-> RXD == DIBIT_IDLE)
      else $error("data before lock");
  slow_hold_a:
    assert property (SPEED_10M && $changed(RXD) |=> $stable(RXD)[*8] ##1 $stable(RXD))
      else $error("slow dibit too short");
  drop_cause_a:
    assert property ($fell(CRS_DV) |-> !$past(CARRIER))
      else $error("drop with carrier");
  drain_toggle_a:
    assert property (!SPEED_10M && $rose(CRS_DV) && $past(CRS_DV, 2) |=> !CRS_DV)
      else $error("no toggle");
  carrier_hold_a:
    assert property (!SPEED_10M && CARRIER && CRS_DV |=> CRS_DV)
      else $error("flag dropped early");
  false_code_a:
    assert property (!SPEED_10M && FALSE_CARRIER && CRS_DV
      |=> (RXD == DIBIT_FALSE && RX_ER)[*4]) else $error("bad false code");
  idle_zero_a:
    assert property (!SPEED_10M && !CRS_DV && !$past(CRS_DV) |-> RXD == DIBIT_IDLE)
      else $error("idle data");
  tx_pass_a:
    assert property (TX_EN |=> TX_ACTIVE && TX_DIBIT == $past(TXD))
      else $error("tx lost");
endmodule : rrp_rx_port_sva

bind rrp_rx_port rrp_rx_port_sva i_rrp_rx_port_sva (
  .CLK(CLK), .SYS_RST(SYS_RST), .SPEED_10M(SPEED_10M), .CARRIER(CARRIER),
  .FALSE_CARRIER(FALSE_CARRIER), .TXD(TXD), .TX_EN(TX_EN), .TX_DIBIT(TX_DIBIT),
  .TX_ACTIVE(TX_ACTIVE), .RXD(RXD), .CRS_DV(CRS_DV), .RX_ER(RX_ER));

// File: rrp_mac_model.sv
/*
  controller receive side: rebuilds nibbles
  assumes one clock; slow mode samples every tenth cycle
*/
`timescale 1ns/100ps
module rrp_mac_model #(
  parameter int OFS = 0
) (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       spd,
  input wire logic [1:0] rxd,
  input wire logic       crs,
  input wire logic       rxer
);
  logic [4:0] got[$];
  logic [3:0] div_q;
  logic       act_q, ph_q, er_q;
  logic [1:0] lo_q;
  // ====
  // any start phase
  always @(posedge clk) begin
    if (rst) begin
      act_q <= 1'h0;
      div_q <= 4'(OFS);
    end else begin
      div_q <= (div_q == 4'h9) ? 4'h0 : div_q + 4'h1;
      if (!spd || div_q == 4'h0) begin
        if (!act_q || !ph_q) begin
          act_q <= act_q || (crs && rxd == 2'h1);
          ph_q <= 1'h1;
          lo_q <= rxd;
          er_q <= rxer;
        end else begin
          ph_q <= 1'h0;
          if (crs) got.push_back({er_q, rxd, lo_q});
          else act_q <= 1'h0;
        end
      end
    end
  end
endmodule : rrp_mac_model

// File: tb.sv
/*
  self-checking bench for rrp_rx_port
  assumes rrp_mac_model and the bound checker
*/
`timescale 1ns/100ps
module tb;
  logic       clk = 0, rst = 1, spd = 0, car = 0, lock = 0, fcar = 0;
  logic       nv = 0, ne = 0, txen = 0, nrdy, txa, crs, rxer;
  logic [3:0] nd = 4'h0;
  logic [1:0] txd = 2'h0, txo, rxd;
  int         err_count = 0, comparisons = 0;

  rrp_rx_port i_rrp_rx_port (
    .CLK(clk), .SYS_RST(rst), .CE(1'h1), .SPEED_10M(spd), .CARRIER(car),
    .DECODE_LOCK(lock), .FALSE_CARRIER(fcar), .NIB_VALID(nv), .NIB_DATA(nd),
    .NIB_ERR(ne), .NIB_READY(nrdy), .TXD(txd), .TX_EN(txen), .TX_DIBIT(txo),
    .TX_ACTIVE(txa), .RXD(rxd), .CRS_DV(crs), .RX_ER(rxer));
  rrp_mac_model #(.OFS(7)) i_mac (.clk(clk), .rst(rst), .spd(spd), .rxd(rxd),
    .crs(crs), .rxer(rxer));

  always #12.5 clk = ~clk;

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic end_sim;
    $display("errors %0d checks %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  task automatic t_tx;
    for (int v = 0; v < 4; v++) begin
      @(negedge clk);
      txen = 1;
      txd = 2'(v);
      @(negedge clk);
      chk("tx", {txa, txo}, 8'(4 + v));
    end
    txen = 0;
  endtask : t_tx

  // ====
  // frame, push 40 nibbles through refusals, drain
  task automatic t_frame(input logic s);
    logic [4:0] exp[$];
    int k, g;
    logic full;
    k = 0;
    g = 0;
    full = 0;
    i_mac.got.delete();
    @(negedge clk);
    spd = s;
    car = 1;
    @(negedge clk);
    lock = 1;
    @(negedge clk);
    lock = 0;
    while (k < 40 && g < 1500) begin
      nv = 1;
      nd = (k < 2) ? 4'h5 : 4'(k * 7);
      ne = (k == 38);
      // ready settled since the last edge decides the coming one
      if (nrdy === 1'h1) begin
        exp.push_back({ne, nd});
        k++;
      end else full = 1;
      @(negedge clk);
      g++;
    end
    nv = 0;
    car = 0;
    chk("pushed", 8'(k), 8'h28);
    while (i_mac.got.size() < exp.size() && g < 3000) begin
      @(negedge clk);
      g++;
    end
    chk("full", full, 8'h1);
    chk("count", 8'(i_mac.got.size()), 8'(exp.size()));
    foreach (exp[i]) chk("nib", 8'(i_mac.got[i]), 8'(exp[i]));
    repeat (25) @(negedge clk);
    chk("idle", {crs, rxd}, 8'h0);
  endtask : t_frame

  task automatic t_false;
    int n;
    @(negedge clk);
    spd = 0;
    car = 1;
    @(negedge clk);
    fcar = 1;
    @(negedge clk);
    fcar = 0;
    repeat (5) begin
      @(negedge clk);
      chk("false", {crs, rxer, rxd}, 8'hE);
    end
    car = 0;
    n = 0;
    while (crs !== 1'h0 && n < 10) begin
      @(negedge clk);
      n++;
    end
    chk("drop", crs, 8'h0);
  endtask : t_false

  initial begin
    repeat (5) @(negedge clk);
    rst = 0;
    chk("reset", {nrdy, crs, rxd}, 8'h8);
    t_tx();
    t_frame(1'h0);
    t_frame(1'h1);
    t_false();
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    end_sim();
  end
endmodule : tb
